// ===== ssrd_top.sv
// serial receiver on an external clock, double buffered, feeding one dma channel
// assumes the partner clocks the link; memory writes are acknowledged on clk_sys

module ssrd_top (
	// system clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 rstn,
	// serial link from the partner
	input  wire logic                 sclk_link,
	input  wire logic                 serial_rx_data_pin,
	output      logic                 receiver_ready_line,
	// serial control levels
	input  wire logic                 receive_enable_bit,
	input  wire logic                 rx_irq_enable,
	input  wire logic                 rx_err_irq_enable,
	input  wire logic                 ready_set,
	// status flags and their clear pulses
	input  wire ssrd_pkg::ssrd_flags_s flag_clr,
	output      ssrd_pkg::ssrd_flags_s flags,
	output      logic [7:0]           receive_holding_reg,
	output      logic                 rx_full_request,
	output      logic                 rx_error_request,
	// dma configuration writes
	input  wire logic [31:0]          sw_wdata,
	input  wire logic                 sw_wr_src,
	input  wire logic                 sw_wr_dst,
	input  wire logic                 sw_wr_cnt,
	input  wire logic                 sw_wr_dte,
	input  wire ssrd_pkg::ssrd_amode_e src_mode,
	input  wire ssrd_pkg::ssrd_amode_e dst_mode,
	input  wire logic                 dma_end_irq_enable,
	input  wire logic                 dma_end_clr,
	// dma readback
	output      logic [31:0]          dma_src_addr_reg,
	output      logic [31:0]          dma_dst_addr_reg,
	output      logic [31:0]          dma_count_reg,
	output      logic                 dma_transfer_enable_bit,
	output      logic                 dma_end_flag,
	output      logic                 dma_end_request,
	// memory write port
	output      logic                 mem_req,
	output      logic [31:0]          mem_addr,
	output      logic [7:0]           mem_wdata,
	input  wire logic                 mem_ack
);

	// next address for a byte access under a mode
	function automatic logic [31:0] next_addr(input logic [31:0] a,
			input ssrd_pkg::ssrd_amode_e m);
		logic [31:0] r;
		r = a;
		case (m)
			ssrd_pkg::AM_FIXED: r = a;
			ssrd_pkg::AM_INC:   r = a + ssrd_pkg::ADDR_STEP;
			ssrd_pkg::AM_DEC:   r = a - ssrd_pkg::ADDR_STEP;
			default:            r = a;
		endcase
		return r;
	endfunction

	ssrd_pkg::ssrd_link_s link_q;
	ssrd_pkg::ssrd_link_s link_d;
	ssrd_pkg::ssrd_sys_s  sys_q;
	ssrd_pkg::ssrd_sys_s  sys_d;

	// link side: shift on each rising serial clock edge
	always_comb begin
		link_d = link_q;
		// lsb arrives first, so bits enter at the top and move down
		link_d.receive_shift_reg = {serial_rx_data_pin, link_q.receive_shift_reg[7:1]};
		link_d.bit_cnt = link_q.bit_cnt + 3'h1;
		if (link_q.bit_cnt == ssrd_pkg::BIT_LAST) begin
			// completed byte parked for the system side, shifting goes on
			link_d.frame_byte = {serial_rx_data_pin, link_q.receive_shift_reg[7:1]};
			link_d.frame_tgl  = ~link_q.frame_tgl;
			link_d.bit_cnt    = 3'h0;
		end
	end

	always_ff @(posedge sclk_link or negedge rstn) begin
		if (!rstn) begin
			link_q <= '0;
		end else begin
			link_q <= link_d;
		end
	end

	// system side
	always_comb begin
		logic new_frame;
		logic dma_done;
		logic full_eff;
		new_frame = 1'b0;
		dma_done  = 1'b0;
		full_eff  = 1'b0;
		sys_d = sys_q;

		// frame toggle crossing, counted once stages two and three agree
		sys_d.tgl_m  = link_q.frame_tgl;
		sys_d.tgl_s2 = sys_q.tgl_m;
		sys_d.tgl_s3 = sys_q.tgl_s2;
		if ((sys_q.tgl_s2 == sys_q.tgl_s3) && (sys_q.tgl_s3 != sys_q.tgl_seen)) begin
			new_frame      = 1'b1;
			sys_d.tgl_seen = sys_q.tgl_s3;
		end

		// software configuration writes
		if (sw_wr_src) begin
			sys_d.dma_src_addr_reg = sw_wdata;
		end
		if (sw_wr_dst) begin
			sys_d.dma_dst_addr_reg = sw_wdata;
		end
		if (sw_wr_cnt) begin
			sys_d.dma_count_reg = sw_wdata;
		end
		if (sw_wr_dte) begin
			sys_d.dma_transfer_enable_bit = sw_wdata[0];
		end

		// dma channel
		case (sys_q.dstate)
			ssrd_pkg::DS_IDLE: begin
				if (sys_q.dma_transfer_enable_bit && sys_q.rx_full_request &&
						(sys_q.dma_count_reg != ssrd_pkg::CNT_ZERO)) begin
					sys_d.mem_req   = 1'b1;
					sys_d.mem_addr  = sys_q.dma_dst_addr_reg;
					sys_d.mem_wdata = sys_q.receive_holding_reg;
					sys_d.dstate    = ssrd_pkg::DS_WRITE;
				end
			end
			ssrd_pkg::DS_WRITE: begin
				if (mem_ack) begin
					dma_done      = 1'b1;
					sys_d.mem_req = 1'b0;
					sys_d.dstate  = ssrd_pkg::DS_IDLE;
					sys_d.dma_src_addr_reg = next_addr(sys_q.dma_src_addr_reg, src_mode);
					sys_d.dma_dst_addr_reg = next_addr(sys_q.dma_dst_addr_reg, dst_mode);
					sys_d.dma_count_reg    = sys_q.dma_count_reg - ssrd_pkg::CNT_STEP;
					if (sys_q.dma_count_reg == ssrd_pkg::CNT_ONE) begin
						sys_d.dma_transfer_enable_bit = 1'b0;
					end
				end
			end
			default: begin
				sys_d.mem_req = 1'b0;
				sys_d.dstate  = ssrd_pkg::DS_IDLE;
			end
		endcase

		// clears first so that a set in the same cycle wins
		sys_d.flags.tx_empty_flag      = sys_q.flags.tx_empty_flag & ~flag_clr.tx_empty_flag;
		sys_d.flags.rx_full_flag       = sys_q.flags.rx_full_flag & ~flag_clr.rx_full_flag;
		sys_d.flags.overrun_flag       = sys_q.flags.overrun_flag & ~flag_clr.overrun_flag;
		sys_d.flags.parity_error_flag  = sys_q.flags.parity_error_flag &
				~flag_clr.parity_error_flag;
		sys_d.flags.framing_error_flag = sys_q.flags.framing_error_flag &
				~flag_clr.framing_error_flag;
		if (dma_done) begin
			sys_d.flags.rx_full_flag = 1'b0;
		end
		sys_d.dma_end_flag = sys_q.dma_end_flag & ~dma_end_clr;
		if (dma_done && (sys_q.dma_count_reg == ssrd_pkg::CNT_ONE)) begin
			sys_d.dma_end_flag = 1'b1;
		end

		// frame arrival, dropped while reception is disabled
		full_eff = sys_q.flags.rx_full_flag & ~dma_done;
		if (new_frame && receive_enable_bit) begin
			if (full_eff) begin
				sys_d.flags.overrun_flag = 1'b1;
			end else begin
				sys_d.receive_holding_reg = link_q.frame_byte;
				sys_d.flags.rx_full_flag  = 1'b1;
			end
		end

		// requests follow their flags and enables; overrun masks the full request
		sys_d.rx_full_request  = sys_d.flags.rx_full_flag & ~sys_d.flags.overrun_flag &
				rx_irq_enable;
		sys_d.rx_error_request = (sys_d.flags.overrun_flag | sys_d.flags.parity_error_flag |
				sys_d.flags.framing_error_flag) & rx_err_irq_enable;
		sys_d.dma_end_request  = sys_d.dma_end_flag & dma_end_irq_enable;

		// ready only with reception and dma both armed
		sys_d.receiver_ready_line = ready_set & receive_enable_bit &
				sys_d.dma_transfer_enable_bit;
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sys_q <= '0;
			sys_q.receive_holding_reg   <= ssrd_pkg::HOLD_RST;
			sys_q.flags.tx_empty_flag   <= ssrd_pkg::TXE_RST;
			sys_q.dma_src_addr_reg      <= ssrd_pkg::ADDR_RST;
			sys_q.dma_dst_addr_reg      <= ssrd_pkg::ADDR_RST;
			sys_q.dma_count_reg         <= ssrd_pkg::CNT_RST;
			sys_q.dstate                <= ssrd_pkg::DS_IDLE;
		end else begin
			sys_q <= sys_d;
		end
	end

	// outputs straight from flops; shift register stays internal
	assign receiver_ready_line     = sys_q.receiver_ready_line;
	assign flags                   = sys_q.flags;
	assign receive_holding_reg     = sys_q.receive_holding_reg;
	assign rx_full_request         = sys_q.rx_full_request;
	assign rx_error_request        = sys_q.rx_error_request;
	assign dma_src_addr_reg        = sys_q.dma_src_addr_reg;
	assign dma_dst_addr_reg        = sys_q.dma_dst_addr_reg;
	assign dma_count_reg           = sys_q.dma_count_reg;
	assign dma_transfer_enable_bit = sys_q.dma_transfer_enable_bit;
	assign dma_end_flag            = sys_q.dma_end_flag;
	assign dma_end_request         = sys_q.dma_end_request;
	assign mem_req                 = sys_q.mem_req;
	assign mem_addr                = sys_q.mem_addr;
	assign mem_wdata               = sys_q.mem_wdata;

endmodule

// ===== ssrd_pkg.sv
// package for the clock-synchronous serial receiver with its dma channel
// assumes clk_sys at 250 MHz and a free-standing external serial clock
package ssrd_pkg;

	// frame and data widths
	localparam int unsigned FRAME_BITS = 8;
	localparam int unsigned ADDR_W     = 32;
	localparam int unsigned CNT_W      = 32;

	// bit counter at the last bit of a frame
	localparam logic [2:0] BIT_LAST = 3'h7;

	// one byte-sized access per transfer
	localparam logic [31:0] ADDR_STEP = 32'h0000_0001;
	localparam logic [31:0] CNT_STEP  = 32'h0000_0001;
	localparam logic [31:0] CNT_ONE   = 32'h0000_0001;
	localparam logic [31:0] CNT_ZERO  = 32'h0000_0000;

	// reset values
	localparam logic [7:0]  HOLD_RST  = 8'h00;
	localparam logic [31:0] ADDR_RST  = 32'h0000_0000;
	localparam logic [31:0] CNT_RST   = 32'h0000_0000;
	localparam logic        TXE_RST   = 1'b1;

	// address update modes
	typedef enum logic [1:0] {
		AM_FIXED,
		AM_INC,
		AM_DEC
	} ssrd_amode_e;

	// dma channel states
	typedef enum logic [0:0] {
		DS_IDLE,
		DS_WRITE
	} ssrd_dstate_e;

	// status flags that software may only clear
	typedef struct packed {
		logic tx_empty_flag;
		logic rx_full_flag;
		logic overrun_flag;
		logic parity_error_flag;
		logic framing_error_flag;
	} ssrd_flags_s;

	// state on the serial clock
	typedef struct packed {
		logic [7:0] receive_shift_reg;
		logic [2:0] bit_cnt;
		logic [7:0] frame_byte;
		logic       frame_tgl;
	} ssrd_link_s;

	// state on the system clock
	typedef struct packed {
		logic         tgl_m;
		logic         tgl_s2;
		logic         tgl_s3;
		logic         tgl_seen;
		logic [7:0]   receive_holding_reg;
		ssrd_flags_s  flags;
		logic         rx_full_request;
		logic         rx_error_request;
		logic [31:0]  dma_src_addr_reg;
		logic [31:0]  dma_dst_addr_reg;
		logic [31:0]  dma_count_reg;
		logic         dma_transfer_enable_bit;
		logic         dma_end_flag;
		logic         dma_end_request;
		ssrd_dstate_e dstate;
		logic         mem_req;
		logic [31:0]  mem_addr;
		logic [7:0]   mem_wdata;
		logic         receiver_ready_line;
	} ssrd_sys_s;

endpackage

// ===== ssrd_monitor.sv
// port assertions for the serial receiver and its dma channel
// assumes binding to ssrd_top; every check runs on clk_sys
module ssrd_monitor (
	// clock and reset
	input wire logic                  clk_sys,
	input wire logic                  rstn,
	// control inputs
	input wire logic                  receive_enable_bit,
	input wire logic                  rx_irq_enable,
	input wire logic                  rx_err_irq_enable,
	input wire logic                  ready_set,
	input wire ssrd_pkg::ssrd_amode_e src_mode,
	input wire ssrd_pkg::ssrd_amode_e dst_mode,
	input wire logic                  mem_ack,
	// design outputs
	input wire logic                  receiver_ready_line,
	input wire ssrd_pkg::ssrd_flags_s flags,
	input wire logic                  rx_full_request,
	input wire logic                  rx_error_request,
	input wire logic [31:0]           dma_src_addr_reg,
	input wire logic [31:0]           dma_dst_addr_reg,
	input wire logic [31:0]           dma_count_reg,
	input wire logic                  dma_transfer_enable_bit,
	input wire logic                  dma_end_flag,
	input wire logic                  mem_req,
	input wire logic [31:0]           mem_addr
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	// acknowledged transfer with bytes left, destination incrementing
	sequence s_ack_mid;
		mem_req && mem_ack && dma_count_reg > 32'h1 && dst_mode == ssrd_pkg::AM_INC;
	endsequence
	// acknowledged transfer of the last byte
	sequence s_ack_last;
		mem_req && mem_ack && dma_count_reg == 32'h1;
	endsequence
	full_req_a: assert property (
		rx_full_request |-> flags.rx_full_flag && $past(rx_irq_enable))
		else $error("full request without cause");
	err_req_a: assert property (
		rx_error_request |-> flags.overrun_flag && $past(rx_err_irq_enable))
		else $error("error request without cause");
	ready_cfg_a: assert property (
		receiver_ready_line |-> $past(ready_set && receive_enable_bit))
		else $error("ready without configuration");
	req_hold_a: assert property (
		mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
		else $error("memory request not held");
	count_step_a: assert property (
		s_ack_mid |=> dma_count_reg == $past(dma_count_reg) - 32'h1
			&& dma_dst_addr_reg == $past(dma_dst_addr_reg) + 32'h1)
		else $error("count or destination step wrong");
	src_fixed_a: assert property (
		mem_req && mem_ack && src_mode == ssrd_pkg::AM_FIXED |=> $stable(dma_src_addr_reg))
		else $error("fixed source moved");
	block_end_a: assert property (
		s_ack_last |=> dma_count_reg == 32'h0 && !dma_transfer_enable_bit && dma_end_flag)
		else $error("block end missing");
	start_gate_a: assert property (
		$rose(mem_req) |-> $past(dma_transfer_enable_bit && rx_full_request && dma_count_reg != 0))
		else $error("transfer started without cause");
endmodule

bind ssrd_top ssrd_monitor mon (.*);

// ===== ssrd_partner.sv
// serial transmitter that clocks bytes into the receiver
// assumes the bench calls send and the receiver drives ready
module ssrd_partner (
	// link to the receiver
	input  wire logic ready_line,
	output logic      link_clk,
	output logic      link_data
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		link_clk = 1'b0;
		link_data = 1'b1;
	end
	task automatic send(input logic [7:0] b);
		wait (ready_line === 1'b1);
		#3.3;
		for (int i = 0; i < 8; i++) begin
			link_data = b[i];
			#7.5 link_clk = 1'b1;
			#7.5 link_clk = 1'b0;
		end
		link_data = ~b[7];
	endtask
endmodule

// ===== test_sync_serial_rx_dma.sv
// self-checking bench for the serial receiver and its dma channel
// assumes ssrd_pkg, ssrd_top, ssrd_partner and ssrd_monitor compiled first
module test_sync_serial_rx_dma;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys, rstn, sclk_link, serial_rx_data_pin, receiver_ready_line, ready_set;
	logic receive_enable_bit, rx_irq_enable, rx_err_irq_enable, rx_full_request;
	logic rx_error_request, dma_end_irq_enable, dma_end_clr, mem_req, mem_ack;
	logic sw_wr_src, sw_wr_dst, sw_wr_cnt, sw_wr_dte;
	logic dma_transfer_enable_bit, dma_end_flag, dma_end_request;
	logic [7:0]  receive_holding_reg, mem_wdata;
	logic [31:0] sw_wdata, dma_src_addr_reg, dma_dst_addr_reg, dma_count_reg, mem_addr;
	ssrd_pkg::ssrd_flags_s flag_clr, flags;
	ssrd_pkg::ssrd_amode_e src_mode, dst_mode;
	int num_errors, n_compared, cyc, k;
	// destination address and byte expected for each byte sent
	logic [39:0] rows[3] = '{40'h00002000_a5, 40'h00002001_3c, 40'h00002002_01};

	ssrd_top dut (.*);
	ssrd_partner link (
		.ready_line(receiver_ready_line),
		.link_clk  (sclk_link),
		.link_data (serial_rx_data_pin)
	);

	always #2 clk_sys = ~clk_sys;

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic finish_test;
		if (num_errors == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// one-hot strobe: src, dst, count, enable from msb down
	task automatic wr(input logic [3:0] s, input logic [31:0] v);
		@(posedge clk_sys);
		sw_wdata <= v;
		{sw_wr_src, sw_wr_dst, sw_wr_cnt, sw_wr_dte} <= s;
		@(posedge clk_sys);
		{sw_wr_src, sw_wr_dst, sw_wr_cnt, sw_wr_dte} <= 4'h0;
	endtask

	// memory acknowledges each write a cycle later and checks it
	always @(posedge clk_sys) begin
		mem_ack <= mem_req & ~mem_ack;
		if (mem_req && mem_ack) begin
			chk("mem_addr", rows[k][39:8], mem_addr);
			chk("mem_wdata", 32'(rows[k][7:0]), 32'(mem_wdata));
			k++;
		end
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			finish_test();
		end
	end

	initial begin
		{clk_sys, rstn, mem_ack, dma_end_clr, sw_wdata, flag_clr} = '0;
		{sw_wr_src, sw_wr_dst, sw_wr_cnt, sw_wr_dte} = 4'h0;
		{receive_enable_bit, rx_irq_enable, rx_err_irq_enable, ready_set} = 4'hf;
		dma_end_irq_enable = 1'b1;
		src_mode = ssrd_pkg::AM_FIXED;
		dst_mode = ssrd_pkg::AM_INC;
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		#1 chk("flags", 32'h10, 32'(flags));
		wr(4'h8, 32'h100);
		wr(4'h4, 32'h2000);
		wr(4'h2, 32'h3);
		#1 chk("ready", 32'h0, 32'(receiver_ready_line));
		wr(4'h1, 32'h1);
		foreach (rows[i]) link.send(rows[i][7:0]);
		for (int t = 0; t < 40 && dma_end_flag !== 1'b1; t++) @(posedge clk_sys);
		#1 chk("count", 32'h0, dma_count_reg);
		chk("dst_addr", 32'h2003, dma_dst_addr_reg);
		chk("src_addr", 32'h100, dma_src_addr_reg);
		chk("end", 32'h3, 32'({dma_transfer_enable_bit, dma_end_flag, dma_end_request}));
		chk("flags", 32'h10, 32'(flags));
		chk("holding", 32'h1, 32'(receive_holding_reg));
		// enabled with a zero count: bytes pile up and overrun
		wr(4'h1, 32'h1);
		link.send(8'h5a);
		link.send(8'hc3);
		repeat (8) @(posedge clk_sys);
		#1 chk("holding", 32'h5a, 32'(receive_holding_reg));
		chk("flags", 32'h1c, 32'(flags));
		chk("requests", 32'h1, 32'({mem_req, rx_full_request, rx_error_request}));
		@(posedge clk_sys) flag_clr <= '1;
		@(posedge clk_sys) flag_clr <= '0;
		#1 chk("flags", 32'h0, 32'(flags));
		// receive interrupts off: byte lands, request stays low
		@(posedge clk_sys) rx_irq_enable <= 1'b0;
		link.send(8'h77);
		repeat (8) @(posedge clk_sys);
		#1 chk("holding", 32'h77, 32'(receive_holding_reg));
		chk("flags", 32'h08, 32'(flags));
		chk("requests", 32'h0, 32'({mem_req, rx_full_request, rx_error_request}));
		finish_test();
	end
endmodule
